//--- rtl/hsq_homing_seq.sv
`timescale 1ns/100ps
module hsq_homing_seq
  import hsq_pkg::*;
(
  input  wire logic             sys_clk_i,
  input  wire logic             srst_i,
  input  wire logic             hsel_i,
  input  wire logic [31:0]      haddr_i,
  input  wire logic [1:0]       htrans_i,
  input  wire logic             hwrite_i,
  input  wire logic [2:0]       hsize_i,
  input  wire logic [31:0]      hwdata_i,
  input  wire logic             hready_i,
  output logic      [31:0]      hrdata_o,
  output logic                  hreadyout_o,
  output logic                  hresp_o,
  input  wire logic             positive_travel_limit_i,
  input  wire logic             negative_travel_limit_i,
  input  wire logic             home_sensor_i,
  input  wire logic             index_pulse_i,
  output logic      [SPD_W-1:0] speed_cmd_o,
  output logic                  dir_rev_o,
  output logic                  stop_o,
  output logic                  busy_o,
  output logic                  homing_done_o,
  output logic                  homing_error_o
);

  // Build a step from {last, cont, rev, zero} flags and a trigger
  function automatic hsq_step_t st(input logic [3:0] f, input hsq_trig_t t);
    st = hsq_step_t'({f, t});
  endfunction : st

  // Step table per method, start branch and step number
  function automatic hsq_step_t step_of(input logic [7:0] m, input hsq_branch_t b,
                                        input logic s);
    hsq_step_t r;
    r = st(4'h8, TRG_INDEX);
    case (m)
      M07: begin
        if (b == BR_LIM) r = s ? st(4'hB, TRG_INDEX) : st(4'h6, TRG_HOME_F);
        else if (b == BR_ON) r = st(4'hB, TRG_INDEX);
        else r = s ? st(4'hB, TRG_INDEX) : st(4'h0, TRG_HOME_R);
      end
      M09: begin
        if (b == BR_LIM) r = s ? st(4'hB, TRG_INDEX) : st(4'h6, TRG_HOME_R);
        else if (b == BR_ON) r = s ? st(4'hB, TRG_INDEX) : st(4'h7, TRG_HOME_F);
        else r = s ? st(4'hB, TRG_INDEX) : st(4'h0, TRG_HOME_R);
      end
      M11: begin
        if (b == BR_LIM) r = s ? st(4'h9, TRG_INDEX) : st(4'h4, TRG_HOME_F);
        else if (b == BR_ON) r = s ? st(4'h9, TRG_INDEX) : st(4'h5, TRG_HOME_F);
        else r = s ? st(4'hB, TRG_INDEX) : st(4'h2, TRG_HOME_R);
      end
      M13: begin
        if (b == BR_LIM) r = s ? st(4'hB, TRG_INDEX) : st(4'h0, TRG_HOME_F);
        else if (b == BR_ON) r = s ? st(4'hB, TRG_INDEX) : st(4'h7, TRG_HOME_F);
        else r = s ? st(4'hB, TRG_INDEX) : st(4'h2, TRG_HOME_F);
      end
      M17: begin
        if (b == BR_ON) r = st(4'h9, TRG_NEG_F);
        else r = s ? st(4'h9, TRG_NEG_F) : st(4'h2, TRG_NEG_R);
      end
      M18: begin
        if (b == BR_ON) r = st(4'hB, TRG_POS_F);
        else r = s ? st(4'hB, TRG_POS_F) : st(4'h0, TRG_POS_R);
      end
      // method 19 home edge, no index
      M19: begin
        if (b == BR_ON) r = st(4'hB, TRG_HOME_F);
        else r = s ? st(4'hB, TRG_HOME_F) : st(4'h0, TRG_HOME_R);
      end
      M21: begin
        if (b == BR_ON) r = st(4'h9, TRG_HOME_F);
        else r = s ? st(4'hB, TRG_HOME_F) : st(4'h2, TRG_HOME_R);
      end
      // method 23 leaves home in reverse
      M23: begin
        if (b == BR_LIM) r = s ? st(4'hB, TRG_HOME_F) : st(4'h6, TRG_HOME_R);
        else if (b == BR_ON) r = st(4'hB, TRG_HOME_F);
        else r = s ? st(4'hB, TRG_HOME_F) : st(4'h0, TRG_HOME_R);
      end
      M25: begin
        if (b == BR_LIM) r = st(4'hA, TRG_HOME_R);
        else r = s ? st(4'hB, TRG_HOME_R) : st(4'h0, TRG_HOME_F);
      end
      default: r = st(4'h8, TRG_INDEX);
    endcase
    return r;
  endfunction : step_of

  // Trigger match against edge pulses
  function automatic logic trig_hit(input hsq_trig_t t, input hsq_sns_t n);
    logic h;
    h = 1'b0;
    unique case (t)
      TRG_HOME_R: h = n.rise[SNS_HOME];
      TRG_HOME_F: h = n.fall[SNS_HOME];
      TRG_POS_R:  h = n.rise[SNS_POS];
      TRG_POS_F:  h = n.fall[SNS_POS];
      TRG_NEG_R:  h = n.rise[SNS_NEG];
      TRG_NEG_F:  h = n.fall[SNS_NEG];
      TRG_INDEX:  h = n.rise[SNS_IDX];
    endcase
    return h;
  endfunction : trig_hit

  hsq_sns_t         sns;
  hsq_ap_t          ap_reg;
  logic             wr_pend_reg;
  logic             rd_pend_reg;
  logic [31:0]      hrdata_reg;
  logic [31:0]      rd_mux;
  logic             ap_valid;
  logic             start;
  logic [7:0]       method_reg;
  logic [SPD_W-1:0] spd_sw_reg;
  logic [SPD_W-1:0] spd_zero_reg;
  logic [SPD_W-1:0] accel_reg;
  hsq_state_t       state_reg;
  hsq_state_t       state_next;
  hsq_branch_t      branch_reg;
  hsq_branch_t      branch_next;
  logic             step_reg;
  logic             step_next;
  logic [7:0]       run_m_reg;
  logic [7:0]       run_m_next;
  hsq_after_t       after_reg;
  hsq_after_t       after_next;
  hsq_step_t        cur;
  hsq_step_t        nxt;
  logic             dir_rev_reg;
  logic             done_reg;
  logic             err_reg;
  logic             unsup_reg;
  logic             supported;
  logic             pos_first;
  logic             neg_first;
  logic             lim_first;
  logic             err_lim;
  logic             on_sns;
  logic [SPD_W-1:0] target;
  logic [SPD_W-1:0] speed;

  hsq_sync u_sync (
    .sys_clk_i (sys_clk_i),
    .srst_i    (srst_i),
    .raw_i     ({index_pulse_i, home_sensor_i, negative_travel_limit_i,
                 positive_travel_limit_i}),
    .sns_o     (sns)
  );

  // AHB address phase capture; reads take one wait state so data comes from a flop
  assign ap_valid = hsel_i && htrans_i[1] && hready_i;

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      ap_reg      <= '0;
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
    end else begin
      if (ap_valid) ap_reg <= '{ok: (haddr_i[31:8] == '0), off: haddr_i[7:0]};
      wr_pend_reg <= ap_valid && hwrite_i;
      rd_pend_reg <= ap_valid && !hwrite_i;
    end
  end

  // Read mux; unmapped offsets read zero
  always_comb begin
    rd_mux = '0;
    if (ap_reg.ok) begin
      case (ap_reg.off)
        OFF_METHOD:   rd_mux = {24'h000000, method_reg};
        OFF_SPD_SW:   rd_mux = {16'h0000, spd_sw_reg};
        OFF_SPD_ZERO: rd_mux = {16'h0000, spd_zero_reg};
        OFF_ACCEL:    rd_mux = {16'h0000, accel_reg};
        OFF_STATUS:   rd_mux = {24'h000000, sns.lvl, unsup_reg, err_reg, done_reg,
                                (state_reg != ST_IDLE)};
        OFF_SPEED:    rd_mux = {15'h0000, dir_rev_reg, speed};
        default:      rd_mux = '0;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) hrdata_reg <= '0;
    else if (rd_pend_reg) hrdata_reg <= rd_mux;
  end

  assign hrdata_o    = hrdata_reg;
  assign hreadyout_o = !rd_pend_reg;
  assign hresp_o     = 1'b0;

  // Configuration writes; speeds and accel may change mid-run and take effect at once, a new method only at the next start
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      method_reg   <= METHOD_RST;
      spd_sw_reg   <= SPD_SW_RST;
      spd_zero_reg <= SPD_ZERO_RST;
      accel_reg    <= ACCEL_RST;
    end else if (wr_pend_reg && ap_reg.ok) begin
      case (ap_reg.off)
        OFF_METHOD:   method_reg   <= hwdata_i[7:0];
        OFF_SPD_SW:   spd_sw_reg   <= hwdata_i[SPD_W-1:0];
        OFF_SPD_ZERO: spd_zero_reg <= hwdata_i[SPD_W-1:0];
        OFF_ACCEL:    accel_reg    <= hwdata_i[SPD_W-1:0];
        default:      ;
      endcase
    end
  end

  // Start request; ignored while a run is in progress
  assign start = wr_pend_reg && ap_reg.ok && (ap_reg.off == OFF_CTRL) &&
                 hwdata_i[CTRL_START] && (state_reg == ST_IDLE);

  always_comb begin
    unique case (method_reg)
      M07, M09, M11, M13, M17, M18, M19, M21, M23, M25: supported = 1'b1;
      default: supported = 1'b0;
    endcase
  end

  assign cur       = step_of(run_m_reg, branch_reg, step_reg);
  assign nxt       = step_of(run_m_next, branch_next, step_next);
  assign pos_first = (run_m_reg == M07) || (run_m_reg == M09) ||
                     (run_m_reg == M23) || (run_m_reg == M25);
  assign neg_first = (run_m_reg == M11) || (run_m_reg == M13);

  // limit met before home switches branch
  assign lim_first = (branch_reg == BR_OFF) && !step_reg &&
                     ((pos_first && sns.rise[SNS_POS]) || (neg_first && sns.rise[SNS_NEG]));

  assign err_lim = (sns.lvl[SNS_NEG] && (pos_first || run_m_reg == M18 ||
                                         run_m_reg == M19 || run_m_reg == M21)) ||
                   (sns.lvl[SNS_POS] && (neg_first || run_m_reg == M17 ||
                                         run_m_reg == M19 || run_m_reg == M21));

  // Start branch: on the limit or sensor that the method searches for
  always_comb begin
    if (method_reg == M17) on_sns = sns.lvl[SNS_NEG];
    else if (method_reg == M18) on_sns = sns.lvl[SNS_POS];
    else on_sns = sns.lvl[SNS_HOME];
  end

  // Sequencer next state
  always_comb begin
    state_next  = state_reg;
    branch_next = branch_reg;
    step_next   = step_reg;
    run_m_next  = run_m_reg;
    after_next  = after_reg;
    unique case (state_reg)
      ST_IDLE: begin
        if (start && supported) begin
          state_next = ST_RUN;
          run_m_next = method_reg;
          step_next  = 1'b0;
          if ((method_reg == M07 || method_reg == M09 || method_reg == M23 ||
               method_reg == M25) && sns.lvl[SNS_POS]) branch_next = BR_LIM;
          else if ((method_reg == M11 || method_reg == M13) && sns.lvl[SNS_NEG])
            branch_next = BR_LIM;
          else branch_next = on_sns ? BR_ON : BR_OFF;
        end
      end
      ST_RUN: begin
        if (err_lim) begin
          state_next = ST_BRAKE;
          after_next = AF_ERROR;
        end else if (lim_first) begin
          state_next = ST_BRAKE;
          after_next = AF_LIMIT;
        end else if (trig_hit(cur.trig, sns)) begin
          if (cur.last) begin
            state_next = ST_BRAKE;
            after_next = AF_DONE;
          end else if (cur.cont) begin
            step_next = 1'b1;
          end else begin
            state_next = ST_BRAKE;
            after_next = AF_NEXT;
          end
        end
      end
      ST_BRAKE: begin
        // Direction may only flip once the axis stands still
        if (speed == '0) begin
          unique case (after_reg)
            AF_NEXT: begin
              state_next = ST_RUN;
              step_next  = 1'b1;
            end
            AF_LIMIT: begin
              state_next  = ST_RUN;
              branch_next = BR_LIM;
              step_next   = 1'b0;
            end
            AF_DONE, AF_ERROR: state_next = ST_IDLE;
          endcase
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      state_reg  <= ST_IDLE;
      branch_reg <= BR_OFF;
      step_reg   <= 1'b0;
      run_m_reg  <= METHOD_RST;
      after_reg  <= AF_DONE;
    end else begin
      state_reg  <= state_next;
      branch_reg <= branch_next;
      step_reg   <= step_next;
      run_m_reg  <= run_m_next;
      after_reg  <= after_next;
    end
  end

  // Travel direction follows the step about to run
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) dir_rev_reg <= 1'b0;
    else if (state_next == ST_RUN) dir_rev_reg <= nxt.rev;
  end

  // completion and error flags; every start clears done, and sets error and unsupported for an unsupported method
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      done_reg  <= 1'b0;
      err_reg   <= 1'b0;
      unsup_reg <= 1'b0;
    end else if (start) begin
      done_reg  <= 1'b0;
      err_reg   <= !supported;
      unsup_reg <= !supported;
    end else if (state_reg == ST_BRAKE && state_next == ST_IDLE) begin
      done_reg <= (after_reg == AF_DONE);
      err_reg  <= (after_reg == AF_ERROR);
    end
  end

  // search speed by step kind; zero while braking
  assign target = (state_reg != ST_RUN) ? '0 : (cur.zero ? spd_zero_reg : spd_sw_reg);

  hsq_ramp u_ramp (
    .sys_clk_i (sys_clk_i),
    .srst_i    (srst_i),
    .target_i  (target),
    .accel_i   (accel_reg),
    .speed_o   (speed)
  );

  assign speed_cmd_o    = speed;
  assign dir_rev_o      = dir_rev_reg;
  assign stop_o         = (state_reg != ST_RUN);
  assign busy_o         = (state_reg != ST_IDLE);
  assign homing_done_o  = done_reg;
  assign homing_error_o = err_reg;

endmodule : hsq_homing_seq

//--- rtl/hsq_pkg.sv
package hsq_pkg;

  // Speed and acceleration word width
  localparam int SPD_W = 16;

  // Register byte offsets
  localparam logic [7:0] OFF_CTRL     = 8'h00;
  localparam logic [7:0] OFF_METHOD   = 8'h04;
  localparam logic [7:0] OFF_SPD_SW   = 8'h08;
  localparam logic [7:0] OFF_SPD_ZERO = 8'h0C;
  localparam logic [7:0] OFF_ACCEL    = 8'h10;
  localparam logic [7:0] OFF_STATUS   = 8'h14;
  localparam logic [7:0] OFF_SPEED    = 8'h18;

  // Field positions
  localparam int CTRL_START   = 0;
  localparam int STAT_BUSY    = 0;
  localparam int STAT_DONE    = 1;
  localparam int STAT_ERR     = 2;
  localparam int STAT_UNSUP   = 3;
  localparam int STAT_SNS_LSB = 4;
  localparam int SPEED_REV    = 16;

  // Reset values
  localparam logic [7:0]       METHOD_RST   = 8'h13;
  localparam logic [SPD_W-1:0] SPD_SW_RST   = 16'h0100;
  localparam logic [SPD_W-1:0] SPD_ZERO_RST = 16'h0040;
  localparam logic [SPD_W-1:0] ACCEL_RST    = 16'h0000;

  // Supported method numbers
  localparam logic [7:0] M07 = 8'h07;
  localparam logic [7:0] M09 = 8'h09;
  localparam logic [7:0] M11 = 8'h0B;
  localparam logic [7:0] M13 = 8'h0D;
  localparam logic [7:0] M17 = 8'h11;
  localparam logic [7:0] M18 = 8'h12;
  localparam logic [7:0] M19 = 8'h13;
  localparam logic [7:0] M21 = 8'h15;
  localparam logic [7:0] M23 = 8'h17;
  localparam logic [7:0] M25 = 8'h19;

  // Sensor slots
  localparam int SNS_POS  = 0;
  localparam int SNS_NEG  = 1;
  localparam int SNS_HOME = 2;
  localparam int SNS_IDX  = 3;
  localparam int SNS_N    = 4;

  typedef enum logic [2:0] {
    TRG_HOME_R, TRG_HOME_F, TRG_POS_R, TRG_POS_F, TRG_NEG_R, TRG_NEG_F, TRG_INDEX
  } hsq_trig_t;

  // One search step: flags {last, cont, rev, zero} then trigger
  typedef struct packed {
    logic      last;
    logic      cont;
    logic      rev;
    logic      zero;
    hsq_trig_t trig;
  } hsq_step_t;

  typedef struct packed {
    logic [SNS_N-1:0] lvl;
    logic [SNS_N-1:0] rise;
    logic [SNS_N-1:0] fall;
  } hsq_sns_t;

  typedef struct packed {
    logic       ok;
    logic [7:0] off;
  } hsq_ap_t;

  typedef enum logic [1:0] {BR_OFF, BR_ON, BR_LIM} hsq_branch_t;
  typedef enum {ST_IDLE, ST_RUN, ST_BRAKE} hsq_state_t;
  typedef enum {AF_NEXT, AF_LIMIT, AF_DONE, AF_ERROR} hsq_after_t;

endpackage : hsq_pkg

//--- rtl/hsq_sync.sv
`timescale 1ns/100ps
module hsq_sync
  import hsq_pkg::*;
(
  input  wire logic             sys_clk_i,
  input  wire logic             srst_i,
  input  wire logic [SNS_N-1:0] raw_i,
  output hsq_sns_t              sns_o
);

  logic [SNS_N-1:0] s1_reg;
  logic [SNS_N-1:0] s2_reg;
  logic [SNS_N-1:0] s3_reg;
  logic [SNS_N-1:0] lvl_reg;
  logic [SNS_N-1:0] rise_reg;
  logic [SNS_N-1:0] fall_reg;

  // Three stages per pin; a change is accepted only once stages two and three agree
  for (genvar g = 0; g < SNS_N; g++) begin : g_pin
    always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
        s1_reg[g]   <= 1'b0;
        s2_reg[g]   <= 1'b0;
        s3_reg[g]   <= 1'b0;
        lvl_reg[g]  <= 1'b0;
        rise_reg[g] <= 1'b0;
        fall_reg[g] <= 1'b0;
      end else begin
        s1_reg[g]   <= raw_i[g];
        s2_reg[g]   <= s1_reg[g];
        s3_reg[g]   <= s2_reg[g];
        lvl_reg[g]  <= (s2_reg[g] == s3_reg[g]) ? s3_reg[g] : lvl_reg[g];
        rise_reg[g] <= (s2_reg[g] == s3_reg[g]) && s3_reg[g] && !lvl_reg[g];
        fall_reg[g] <= (s2_reg[g] == s3_reg[g]) && !s3_reg[g] && lvl_reg[g];
      end
    end
  end

  assign sns_o = '{lvl: lvl_reg, rise: rise_reg, fall: fall_reg};

endmodule : hsq_sync

//--- rtl/hsq_ramp.sv
`timescale 1ns/100ps
module hsq_ramp
  import hsq_pkg::*;
(
  input  wire logic             sys_clk_i,
  input  wire logic             srst_i,
  input  wire logic [SPD_W-1:0] target_i,
  input  wire logic [SPD_W-1:0] accel_i,
  output logic      [SPD_W-1:0] speed_o
);

  logic [SPD_W-1:0] speed_reg;

  // Zero acceleration means step straight to target (immediate stop)
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      speed_reg <= '0;
    end else if (accel_i == '0) begin
      speed_reg <= target_i;
    end else if (speed_reg < target_i) begin
      speed_reg <= (target_i - speed_reg > accel_i) ? speed_reg + accel_i : target_i;
    end else if (speed_reg > target_i) begin
      speed_reg <= (speed_reg - target_i > accel_i) ? speed_reg - accel_i : target_i;
    end
  end

  assign speed_o = speed_reg;

endmodule : hsq_ramp

//--- bench/hsq_axis_model.sv
`timescale 1ns/100ps
module hsq_axis_model
  import hsq_pkg::*;
(
  input  wire logic               sys_clk_i,
  input  wire logic               load_i,
  input  wire logic signed [15:0] load_pos_i,
  input  wire logic [SPD_W-1:0]   speed_i,
  input  wire logic               dir_rev_i,
  output logic signed [15:0]      pos_o,
  output logic                    pos_lim_o,
  output logic                    neg_lim_o,
  output logic                    home_o,
  output logic                    index_o
);
  // One step per cycle while moving; speed size is ignored, so overshoot tracks brake time
  always_ff @(posedge sys_clk_i) begin
    if (load_i) begin
      pos_o <= load_pos_i;
    end else if (speed_i != 16'h0000) begin
      pos_o <= dir_rev_i ? pos_o - 16'sd1 : pos_o + 16'sd1;
    end
  end

  // Limits stay active beyond their edge, home is a band, index 4 steps every 32
  assign pos_lim_o = (pos_o >= 16'sd400);
  assign neg_lim_o = (pos_o <= 16'sd0);
  assign home_o    = (pos_o >= 16'sd200) && (pos_o <= 16'sd260);
  assign index_o   = (pos_o[4:2] == 3'h0);
endmodule : hsq_axis_model

//--- bench/hsq_homing_seq_monitor.sv
`timescale 1ns/100ps
module hsq_homing_seq_monitor
  import hsq_pkg::*;
(
  input wire logic             sys_clk_i,
  input wire logic             srst_i,
  input wire logic             hsel_i,
  input wire logic [1:0]       htrans_i,
  input wire logic             hwrite_i,
  input wire logic             hready_i,
  input wire logic             hreadyout_o,
  input wire logic             hresp_o,
  input wire logic [SPD_W-1:0] speed_cmd_o,
  input wire logic             dir_rev_o,
  input wire logic             stop_o,
  input wire logic             busy_o,
  input wire logic             homing_done_o,
  input wire logic             homing_error_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);

  // Accepted bus requests
  logic rd_acc;
  logic wr_acc;
  logic braking;
  assign rd_acc  = hsel_i && htrans_i[1] && hready_i && !hwrite_i;
  assign wr_acc  = hsel_i && htrans_i[1] && hready_i && hwrite_i;
  assign braking = stop_o && busy_o;

  property p_resp_okay; hresp_o == 1'b0; endproperty
  a_resp_okay: assert property (p_resp_okay) else $error("bus response not okay");
  property p_rd_wait; rd_acc |=> !hreadyout_o ##1 hreadyout_o; endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");
  property p_wr_nowait; wr_acc |=> hreadyout_o; endproperty
  a_wr_nowait: assert property (p_wr_nowait) else $error("write stalled");
  property p_stop_idle; !busy_o |-> stop_o; endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("stop low while idle");
  property p_brake_dir; braking && $past(braking) |-> $stable(dir_rev_o); endproperty
  a_brake_dir: assert property (p_brake_dir) else $error("direction moved in brake");
  property p_brake_slow; braking && $past(braking) |-> speed_cmd_o <= $past(speed_cmd_o);
  endproperty
  a_brake_slow: assert property (p_brake_slow) else $error("speed rose in brake");
  property p_start_clear; $rose(busy_o) |-> !homing_done_o && !homing_error_o; endproperty
  a_start_clear: assert property (p_start_clear) else $error("flags kept at start");
  property p_done_idle; $rose(homing_done_o) |-> ##[0:1] !busy_o; endproperty
  a_done_idle: assert property (p_done_idle) else $error("done while busy");
  property p_flag_excl; !(homing_done_o && homing_error_o); endproperty
  a_flag_excl: assert property (p_flag_excl) else $error("done and error together");
  property p_idle_speed; !busy_o |-> speed_cmd_o == 16'h0000; endproperty
  a_idle_speed: assert property (p_idle_speed) else $error("speed while idle");

  c_done: cover property ($rose(homing_done_o));
  c_error: cover property ($rose(homing_error_o));
  c_rev_run: cover property (busy_o && !stop_o && dir_rev_o);
endmodule : hsq_homing_seq_monitor

//--- bench/hsq_homing_seq_tb.sv
`timescale 1ns/100ps
module hsq_homing_seq_tb;
  import hsq_pkg::*;
  typedef struct {logic [7:0] m; int p; logic [2:0] st; int sp; int lo; int hi;} hsq_case_t;
  logic               clk, srst, hsel, hwrite, hreadyout, hresp, ld;
  logic [1:0]         htrans;
  logic [31:0]        haddr, hwdata, hrdata, d;
  logic               plim, nlim, home, idx, dir, stop, busy, done, err;
  logic [SPD_W-1:0]   speed;
  logic signed [15:0] ld_pos, pos;
  int                 bad_count, checks, cyc;
  // Status {unsupported, error, done}, speed check 1 switch 2 zero 3 ramp
  hsq_case_t cases [40] = '{
    '{8'h07,100,3'h1,1,150,199}, '{8'h07,410,3'h1,0,150,199}, '{8'h07,-5,3'h2,0,-99,999},
    '{8'h09,100,3'h1,1,150,199}, '{8'h09,230,3'h1,2,150,199}, '{8'h09,-5,3'h2,0,-99,999},
    '{8'h0B,300,3'h1,1,200,262}, '{8'h0B,-5,3'h1,0,262,310}, '{8'h0B,410,3'h2,0,-99,999},
    '{8'h0D,300,3'h1,1,150,199}, '{8'h0D,-5,3'h1,0,200,310}, '{8'h0D,410,3'h2,0,-99,999},
    '{8'h11,100,3'h1,1,-10,10}, '{8'h11,-5,3'h1,0,-10,10}, '{8'h11,410,3'h2,0,-99,999},
    '{8'h12,100,3'h1,1,390,410}, '{8'h12,-5,3'h2,0,-99,999}, '{8'h13,100,3'h1,1,150,199},
    '{8'h13,410,3'h2,0,-99,999}, '{8'h15,300,3'h1,1,150,199}, '{8'h15,230,3'h1,0,262,310},
    '{8'h15,-5,3'h2,0,-99,999}, '{8'h17,100,3'h1,1,150,199}, '{8'h17,-5,3'h2,0,-99,999},
    '{8'h19,100,3'h1,1,150,310}, '{8'h19,-5,3'h2,0,-99,999}, '{8'h0C,100,3'h6,0,99,101},
    '{8'h0E,100,3'h6,0,99,101}, '{8'h14,100,3'h6,0,99,101}, '{8'h16,100,3'h6,0,99,101},
    '{8'h18,100,3'h6,0,99,101}, '{8'h07,230,3'h1,2,150,229}, '{8'h0B,230,3'h1,2,262,310},
    '{8'h0D,230,3'h1,2,150,199}, '{8'h12,410,3'h1,2,390,410}, '{8'h13,230,3'h1,2,150,199},
    '{8'h17,230,3'h1,2,150,199}, '{8'h17,410,3'h1,1,150,199}, '{8'h19,410,3'h1,1,200,260},
    '{8'h19,230,3'h1,1,200,260}};

  hsq_homing_seq hsq_homing_seq_inst (.sys_clk_i(clk), .srst_i(srst), .hsel_i(hsel),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
    .hwdata_i(hwdata), .hready_i(hreadyout), .hrdata_o(hrdata), .hreadyout_o(hreadyout),
    .hresp_o(hresp), .positive_travel_limit_i(plim), .negative_travel_limit_i(nlim),
    .home_sensor_i(home), .index_pulse_i(idx), .speed_cmd_o(speed), .dir_rev_o(dir),
    .stop_o(stop), .busy_o(busy), .homing_done_o(done), .homing_error_o(err));
  hsq_axis_model hsq_axis_model_inst (.sys_clk_i(clk), .load_i(ld), .load_pos_i(ld_pos),
    .speed_i(speed), .dir_rev_i(dir), .pos_o(pos), .pos_lim_o(plim), .neg_lim_o(nlim),
    .home_o(home), .index_o(idx));

  // Free-running clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Bus write: hold address until ready, then data until ready
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] v);
    hsel <= 1'b1; haddr <= {24'h000000, a}; htrans <= 2'h2; hwrite <= 1'b1;
    do @(negedge clk); while (hreadyout !== 1'b1);
    @(posedge clk);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= v;
    do @(negedge clk); while (hreadyout !== 1'b1);
    @(posedge clk);
  endtask : bus_wr

  // Bus read: data taken at the edge that sees ready high
  task automatic bus_rd(input logic [7:0] a, output logic [31:0] v);
    hsel <= 1'b1; haddr <= {24'h000000, a}; htrans <= 2'h2; hwrite <= 1'b0;
    do @(negedge clk); while (hreadyout !== 1'b1);
    @(posedge clk);
    hsel <= 1'b0; htrans <= 2'h0;
    do @(negedge clk); while (hreadyout !== 1'b1);
    v = hrdata;
    @(posedge clk);
  endtask : bus_rd

  // One homing run from a set axis position
  task automatic run(input hsq_case_t c);
    int n;
    ld_pos <= 16'(c.p); ld <= 1'b1;
    @(posedge clk);
    ld <= 1'b0;
    repeat (8) @(posedge clk);
    bus_wr(OFF_METHOD, {24'h000000, c.m});
    bus_wr(OFF_CTRL, 32'h00000001);
    repeat (4) @(negedge clk);
    if (c.sp == 1) chk({16'h0000, speed}, {16'h0000, SPD_SW_RST});
    if (c.sp == 2) chk({16'h0000, speed}, {16'h0000, SPD_ZERO_RST});
    // Ramp of 0x10 per cycle has made three steps by now
    if (c.sp == 3) chk({16'h0000, speed}, 32'h00000030);
    n = 0;
    while (busy !== 1'b0 && n < 3000) begin
      @(negedge clk);
      n++;
    end
    @(posedge clk);
    bus_rd(OFF_STATUS, d);
    chk({28'h0, d[3:0]}, {28'h0, c.st, 1'b0});
    chk({30'h0, err, done}, {30'h0, c.st[1:0]});
    chk({31'h0, pos >= c.lo && pos <= c.hi}, 32'h1);
    bus_rd(OFF_SPEED, d);
    chk({16'h0000, d[15:0]}, 32'h00000000);
    $display("test method %h from %0d finished", c.m, c.p);
  endtask : run

  task automatic results();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : results

  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      bad_count++;
      results();
    end
  end

  // Main sequence
  initial begin
    srst = 1'b1; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0;
    hwdata = 32'h0; ld = 1'b1; ld_pos = 16'sd100; bad_count = 0; checks = 0; cyc = 0;
    repeat (4) @(posedge clk);
    srst <= 1'b0; ld <= 1'b0;
    bus_rd(OFF_METHOD, d); chk(d, 32'h00000013);
    bus_rd(OFF_SPD_SW, d); chk(d, 32'h00000100);
    bus_rd(OFF_SPD_ZERO, d); chk(d, 32'h00000040);
    bus_rd(OFF_ACCEL, d); chk(d, 32'h00000000);
    bus_rd(OFF_STATUS, d); chk(d, 32'h00000000);
    bus_wr(8'h1C, 32'hFFFFFFFF);
    bus_rd(8'h1C, d); chk(d, 32'h00000000);
    $display("test register reset values finished");
    foreach (cases[i]) run(cases[i]);
    // Ramped stop instead of immediate
    bus_wr(OFF_ACCEL, 32'h00000010);
    bus_rd(OFF_ACCEL, d); chk(d, 32'h00000010);
    run('{8'h13,100,3'h1,3,150,199});
    results();
  end
endmodule : hsq_homing_seq_tb

bind hsq_homing_seq hsq_homing_seq_monitor hsq_homing_seq_monitor_inst (
  .sys_clk_i(sys_clk_i), .srst_i(srst_i), .hsel_i(hsel_i), .htrans_i(htrans_i),
  .hwrite_i(hwrite_i), .hready_i(hready_i), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
  .speed_cmd_o(speed_cmd_o), .dir_rev_o(dir_rev_o), .stop_o(stop_o), .busy_o(busy_o),
  .homing_done_o(homing_done_o), .homing_error_o(homing_error_o));
